// ---- dv/lbda_byte_mem.sv ----
// Byte-wide boot memory model on the private byte bus.
// Assumes registered strobes from the block; reads are combinational.
`timescale 1ns/10ps
module lbda_byte_mem (
  input wire logic mclk_i,                // Local bus clock
  input wire lbda_pkg::lbda_pbus_t pb_i,  // Byte bus strobes
  output logic [7:0] pb_rdata_o           // Byte read data
);
  import lbda_pkg::*;
  logic [7:0] last_q = 8'h00;
  logic [7:0] byte_v;
  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Idle bus toggles so a stale byte never passes for data
  always_comb begin
    byte_v = pb_i.addr[7:0] + pb_i.addr[20:13];
    if (pb_i.oe && pb_i.flash_cs) pb_rdata_o = byte_v;
    else if (pb_i.oe && pb_i.prom_cs) pb_rdata_o = ~byte_v;
    else pb_rdata_o = ~last_q;
  end
  always_ff @(posedge mclk_i) last_q <= pb_rdata_o;
endmodule // lbda_byte_mem

// ---- dv/lbda_top_test.sv ----
// Self-checking bench for the decoder, access timeout and arbiter.
// Assumes the byte memory model sits on the private byte bus.
`timescale 1ns/10ps
module lbda_top_test;
  import lbda_pkg::*;
  // ----------------------------------------------------------------
  // Signals and notes
  // ----------------------------------------------------------------
  localparam int T64 = 40;
  localparam int T256 = 80;
  typedef struct {
    logic transfer_error_ack;
    lbda_rgn_t rg;
    int cyc;
    logic chk;
    logic [31:0] d;
    logic [3:0] g;
  } lbda_note_t;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [3:0] bus_req_i = 4'h0;
  logic ts_i = 1'b0;
  lbda_req_t req_i = '0;
  logic vme_bound_i = 1'b0;
  logic slave_ack_i = 1'b0;
  logic boot_select_jumper_i = 1'b1;
  logic [3:0] bus_grant_o;
  logic ta_o;
  logic transfer_error_ack_o;
  logic [31:0] rdata_o;
  lbda_rgn_t rgn_o;
  logic [7:0] pb_rdata_i;
  lbda_pbus_t pb_o;
  lbda_note_t notes[$];
  lbda_note_t nt;
  int err_total = 0;
  int checks_done = 0;
  int cnt = 0;
  int answers = 0;
  int lim[3];
  logic [31:0] seed = 32'h45FC;
  logic [31:0] off;
  logic [31:0] adr;
  logic [3:0] rr;
  logic [3:0] gexp;
  logic [31:0] wexp = 32'h0;

  lbda_top #(.TMO_64_CYC_P(T64), .TMO_256_CYC_P(T256)) dut (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .bus_req_i(bus_req_i), .bus_grant_o(bus_grant_o),
    .ts_i(ts_i), .req_i(req_i), .vme_bound_i(vme_bound_i), .slave_ack_i(slave_ack_i),
    .boot_select_jumper_i(boot_select_jumper_i), .ta_o(ta_o),
    .transfer_error_ack_o(transfer_error_ack_o), .rdata_o(rdata_o), .rgn_o(rgn_o),
    .pb_rdata_i(pb_rdata_i), .pb_o(pb_o));
  lbda_byte_mem mem (.mclk_i(mclk_i), .pb_i(pb_o), .pb_rdata_o(pb_rdata_i));

  initial begin
    forever #4 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i) cnt <= cnt + 1;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [7:0] mem_byte(input logic fl, input logic [20:0] a);
    return fl ? a[7:0] + a[20:13] : ~(a[7:0] + a[20:13]);
  endfunction
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic summarize();
    if (err_total == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // One local bus cycle; ack > 0 pulses the outside slave ack then
  task automatic acc(input logic [31:0] a, input logic [1:0] tt, input logic wr,
      input logic [31:0] wd, input logic vme, input lbda_rgn_t rg, input logic transfer_error_ack,
      input int lat, input int ack, input logic chk, input logic [31:0] ed);
    int k;
    int a0;
    logic [3:0] r;
    @(posedge mclk_i);
    #1;
    ts_i = 1'b1;
    req_i = '{a, tt, wr, wd};
    vme_bound_i = vme;
    a0 = answers;
    notes.push_back('{transfer_error_ack, rg, cnt + lat, chk, ed, gexp});
    @(posedge mclk_i);
    #1;
    ts_i = 1'b0;
    r = 4'(xs());
    bus_req_i = r;
    if (ack > 0) begin
      repeat (ack - 1) @(posedge mclk_i);
      #1;
      slave_ack_i = 1'b1;
      @(posedge mclk_i);
      #1;
      slave_ack_i = 1'b0;
    end
    k = 0;
    while (answers == a0 && k < 3000) begin
      @(negedge mclk_i);
      k++;
    end
    if (k >= 3000) check("answer missing", 32'h1, 32'h0);
    if (r != 4'h0) gexp = r & (~r + 4'h1);
  endtask
  task automatic wr_reg(input logic [31:0] a, input logic [31:0] v);
    acc(a, 2'h0, 1'b1, v, 1'b0, RGN_REGS, 1'b0, 2, 0, 1'b0, 32'h0);
    acc(a, 2'h1, 1'b0, 32'h0, 1'b0, RGN_REGS, 1'b0, 2, 0, 1'b1, v);
  endtask
  task automatic boot_rd(input logic [31:0] a, input logic fl, input logic [1:0] tt);
    logic [20:0] b;
    logic [31:0] w;
    b = a[20:0] & (fl ? FLASH_ADDR_MASK : PROM_ADDR_MASK);
    for (int i = 0; i < 4; i++) w = {w[23:0], mem_byte(fl, b + 21'(i))};
    acc(a, tt, 1'b0, 32'h0, 1'b0, fl ? RGN_FLASH : RGN_PROM, 1'b0, 19, 0, 1'b1, w);
  endtask

  // ----------------------------------------------------------------
  // Result monitor
  // ----------------------------------------------------------------
  always @(negedge mclk_i) begin
    if (ta_o === 1'b1 || transfer_error_ack_o === 1'b1) begin
      if (notes.size() == 0) check("stray ack", 32'h1, 32'h0);
      else begin
        nt = notes.pop_front();
        check("error ack", 32'(transfer_error_ack_o), 32'(nt.transfer_error_ack));
        check("normal ack", 32'(ta_o), 32'(!nt.transfer_error_ack));
        check("region", 32'(rgn_o), 32'(nt.rg));
        check("answer cycle", 32'(cnt), 32'(nt.cyc));
        check("grant held", 32'(bus_grant_o), 32'(nt.g));
        if (nt.chk) check("read data", rdata_o, nt.d);
      end
      answers++;
    end
  end
  // Byte lanes of a boot write, top lane first
  always @(negedge mclk_i) begin
    if (pb_o.we === 1'b1)
      check("byte lane", 32'(pb_o.wdata), 32'(wexp[8*(3-pb_o.addr[1:0]) +: 8]));
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    lim = '{TMO_8_CYC, T64, T256};
    gexp = GRANT_RST;
    repeat (8) @(posedge mclk_i);
    #1;
    rst_n_i = 1'b1;
    check("reset grant", 32'(bus_grant_o), 32'(GRANT_RST));
    acc(BOOT_CTL_ADDR, 2'h0, 1'b0, 32'h0, 1'b0, RGN_REGS, 1'b0, 2, 0, 1'b1, BOOT_CTL_RST);
    acc(DRAM_CTL_ADDR, 2'h0, 1'b0, 32'h0, 1'b0, RGN_REGS, 1'b0, 2, 0, 1'b1, DRAM_CTL_RST);
    repeat (12) begin
      @(posedge mclk_i);
      #1;
      rr = 4'(xs());
      bus_req_i = rr;
      @(posedge mclk_i);
      #1;
      if (rr != 4'h0) gexp = rr & (~rr + 4'h1);
      check("grant", 32'(bus_grant_o), 32'(gexp));
    end
    for (int j = 0; j < 2; j++) begin
      @(posedge mclk_i);
      #1;
      boot_select_jumper_i = j[0];
      for (int w = 0; w < 4; w++) begin
        off = xs() & 32'h0007FFFC;
        adr = BOOT_HI_BASE + 32'(w[0]) * 32'h200000 + 32'(w[1]) * 32'h180000 + off;
        boot_rd(adr, (w[0] == 1'b0) == j[0], 2'h0);
      end
      boot_rd(BOOT_LOW_BASE + 32'h24, j[0], 2'h2);
    end
    for (int t = 0; t < 3; t++) boot_rd(BOOT_HI_BASE + 32'h40, 1'b1, 2'(t));
    wexp = xs();
    acc(BOOT_HI_BASE + 32'h80, 2'h0, 1'b1, wexp, 1'b0, RGN_FLASH, 1'b0, 19, 0, 1'b0,
        32'h0);
    acc(BOOT_HI_BASE, TT_IACK, 1'b0, 32'h0, 1'b0, RGN_IACK, 1'b0, 4, 3, 1'b0, 32'h0);
    for (int s = 0; s < 4; s++) begin
      wr_reg(BOOT_CTL_ADDR, 32'h4 | 32'(s));
      for (int h = 0; h < 2; h++) begin
        adr = (h == 0 ? HOLE1_BASE : HOLE2_BASE) + (xs() & 32'h0007FFFC);
        if (s < 3) acc(adr, 2'h1, 1'b0, 32'h0, 1'b0, RGN_HOLE, 1'b1, lim[s] + 1, 0, 1'b0,
            32'h0);
        else acc(adr, 2'h1, 1'b0, 32'h0, 1'b0, RGN_HOLE, 1'b0, 1051, 1050, 1'b0,
            32'h0);
      end
    end
    wr_reg(BOOT_CTL_ADDR, 32'h0);
    acc(HOLE1_BASE, 2'h0, 1'b1, 32'h5A, 1'b0, RGN_HOLE, 1'b0, 1051, 1050, 1'b0, 32'h0);
    wr_reg(BOOT_CTL_ADDR, 32'h4);
    acc(SRAM_DEF_BASE + 32'h100, 2'h2, 1'b0, 32'h0, 1'b0, RGN_SRAM, 1'b0, 3, 2, 1'b0,
        32'h0);
    // Onboard I/O reached one access at a time, uncached
    acc(LIO_BASE + 32'h45000, 2'h1, 1'b0, 32'h0, 1'b0, RGN_LIO, 1'b0, 3, 2, 1'b0,
        32'h0);
    acc(VME16_BASE + 32'h10, 2'h0, 1'b0, 32'h0, 1'b0, RGN_VME16, 1'b0, 1051, 1050, 1'b0,
        32'h0);
    acc(32'h40000000, 2'h0, 1'b0, 32'h0, 1'b1, RGN_EXT, 1'b0, 1051, 1050, 1'b0, 32'h0);
    wr_reg(DRAM_CTL_ADDR, xs() & 32'hFEFFFFFF);
    // Alias off before DRAM on, as boot software must
    wr_reg(BOOT_CTL_ADDR, 32'h00100004);
    acc(32'h24, 2'h0, 1'b0, 32'h0, 1'b0, RGN_EXT, 1'b0, 3, 2, 1'b0, 32'h0);
    wr_reg(DRAM_CTL_ADDR, 32'h01000000);
    acc(32'h24, 2'h0, 1'b0, 32'h0, 1'b0, RGN_DRAM, 1'b0, 3, 2, 1'b0, 32'h0);
    summarize();
  end

  initial begin
    repeat (30000) @(posedge mclk_i);
    check("run time", 32'h1, 32'h0);
    summarize();
  end
endmodule // lbda_top_test

// ---- logic/lbda_byte_port.sv ----
// Byte-wide private bus engine: one 32-bit access as four byte strobes.
// Assumes start only while idle; devices answer in fixed strobe time.
`timescale 1ns/10ps
module lbda_byte_port (
  input wire logic mclk_i,                  // Local bus clock
  input wire logic rst_n_i,                 // Async reset, active low
  input wire logic start_i,                 // Start one 32-bit access
  input wire logic flash_i,                 // 1 flash, 0 PROM
  input wire lbda_pkg::lbda_req_t req_i,    // Captured request
  input wire logic [7:0] pb_rdata_i,        // Byte bus read data
  output lbda_pkg::lbda_pbus_t pb_o,        // Byte bus strobes
  output logic done_o,                      // Access complete pulse
  output logic [31:0] rdata_o               // Assembled word
);
  import lbda_pkg::*;

  typedef enum logic {BP_IDLE, BP_STROBE} lbda_bp_st_t;
  localparam int BP_TOTAL = 4 * BP_BYTE_CYC + 1;

  lbda_bp_st_t st_q, st_d;
  logic [3:0] cyc_q, cyc_d;
  logic [1:0] idx_q, idx_d;
  logic flash_q, flash_d;
  lbda_req_t req_q, req_d;
  lbda_pbus_t pb_q, pb_d;
  logic done_q, done_d;
  logic [31:0] rd_q, rd_d;

  // Devices smaller than the window alias by dropping upper bits
  function automatic lbda_pbus_t strobe(input lbda_req_t r, input logic fl,
                                        input logic [1:0] idx);
    lbda_pbus_t p;
    p.addr = {r.addr[PB_AW-1:2], idx} & (fl ? FLASH_ADDR_MASK : PROM_ADDR_MASK);
    p.flash_cs = fl;
    p.prom_cs = !fl;
    p.oe = !r.write;
    p.we = r.write;
    p.wdata = r.wdata[8*(3-idx) +: 8];
    return p;
  endfunction

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    cyc_d = cyc_q;
    idx_d = idx_q;
    flash_d = flash_q;
    req_d = req_q;
    pb_d = pb_q;
    done_d = 1'b0;
    rd_d = rd_q;
    unique case (st_q)
      BP_IDLE: begin
        // [RULE_12] Split word into bytes
        if (start_i) begin
          st_d = BP_STROBE;
          cyc_d = 4'h0;
          idx_d = 2'h0;
          flash_d = flash_i;
          req_d = req_i;
          pb_d = strobe(req_i, flash_i, 2'h0);
        end
      end
      BP_STROBE: begin
        cyc_d = cyc_q + 4'h1;
        if (cyc_q == BP_CYC_LAST) begin
          // Big-endian: first byte lands in the top lane
          rd_d = {rd_q[23:0], pb_rdata_i};
          cyc_d = 4'h0;
          if (idx_q == 2'h3) begin
            st_d = BP_IDLE;
            done_d = 1'b1;
            pb_d = '0;
          end else begin
            idx_d = idx_q + 2'h1;
            pb_d = strobe(req_q, flash_q, idx_q + 2'h1);
          end
        end
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q <= BP_IDLE;
      cyc_q <= 4'h0;
      idx_q <= 2'h0;
      flash_q <= 1'b0;
      req_q <= '0;
      pb_q <= '0;
      done_q <= 1'b0;
      rd_q <= 32'h00000000;
    end else begin
      st_q <= st_d;
      cyc_q <= cyc_d;
      idx_q <= idx_d;
      flash_q <= flash_d;
      req_q <= req_d;
      pb_q <= pb_d;
      done_q <= done_d;
      rd_q <= rd_d;
    end
  end

  assign pb_o = pb_q;
  assign done_o = done_q;
  assign rdata_o = rd_q;

  property p_bp_four_bytes;
    @(posedge mclk_i) disable iff (!rst_n_i)
      (st_q == BP_IDLE && start_i) |-> ##BP_TOTAL done_q;
  endproperty
  a_bp_four_bytes: assert property (p_bp_four_bytes) // [RULE_12]
    else $error("byte engine did not finish four bytes on time");

endmodule // lbda_byte_port

// ---- logic/lbda_pkg.sv ----
// Constants, types and memory map for the local bus decode and arbiter.
// Assumes one 125 MHz local bus clock shared by all masters and slaves.
package lbda_pkg;

  // ----------------------------------------------------------------
  // Clock, masters and timeout
  // ----------------------------------------------------------------
  localparam int LBDA_CLK_MHZ = 125;
  localparam int LBDA_MASTERS = 4;
  localparam logic [3:0] GRANT_RST = 4'h8;
  localparam int TMO_8_US = 8;
  localparam int TMO_64_US = 64;
  localparam int TMO_256_US = 256;
  localparam int TMO_8_CYC = TMO_8_US * LBDA_CLK_MHZ;
  localparam int TMO_64_CYC = TMO_64_US * LBDA_CLK_MHZ;
  localparam int TMO_256_CYC = TMO_256_US * LBDA_CLK_MHZ;
  localparam int TMO_CNT_W = 16;
  localparam logic [1:0] TMO_SEL_8 = 2'h0;
  localparam logic [1:0] TMO_SEL_64 = 2'h1;
  localparam logic [1:0] TMO_SEL_256 = 2'h2;
  localparam logic [1:0] TMO_SEL_NEVER = 2'h3;

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  localparam logic [31:0] BOOT_CTL_ADDR = 32'hFFF42040;
  localparam logic [31:0] DRAM_CTL_ADDR = 32'hFFF42048;
  localparam logic [31:0] BOOT_CTL_RST = 32'h00000000;
  localparam logic [31:0] DRAM_CTL_RST = 32'h00000000;
  localparam int BOOT_LOW_OFF_BIT = 20;
  localparam int DRAM_EN_BIT = 24;
  localparam int TMO_EN_BIT = 2;
  localparam int TMO_SEL_LSB = 0;

  // ----------------------------------------------------------------
  // Memory map
  // ----------------------------------------------------------------
  localparam logic [1:0] TT_IACK = 2'h3;
  localparam logic [31:0] BOOT_WIN_MASK = 32'hFFE00000;
  localparam logic [31:0] BOOT_HI_BASE = 32'hFF800000;
  localparam logic [31:0] BOOT_ALT_BASE = 32'hFFA00000;
  localparam logic [31:0] BOOT_LOW_MASK = 32'hFFC00000;
  localparam logic [31:0] BOOT_LOW_BASE = 32'h00000000;
  localparam logic [31:0] DRAM_MASK = 32'hFFC00000;
  localparam logic [31:0] DRAM_BASE = 32'h00000000;
  localparam logic [31:0] HOLE1_MASK = 32'hFFE00000;
  localparam logic [31:0] HOLE1_BASE = 32'hFFC00000;
  localparam logic [31:0] HALF_MB_MASK = 32'hFFF80000;
  localparam logic [31:0] SRAM_DEF_BASE = 32'hFFE00000;
  localparam logic [31:0] HOLE2_BASE = 32'hFFE80000;
  localparam logic [31:0] LIO_MASK = 32'hFFF00000;
  localparam logic [31:0] LIO_BASE = 32'hFFF00000;
  localparam logic [31:0] VME16_MASK = 32'hFFFF0000;
  localparam logic [31:0] VME16_BASE = 32'hFFFF0000;

  // ----------------------------------------------------------------
  // Private byte bus
  // ----------------------------------------------------------------
  localparam int PB_AW = 21;
  localparam logic [20:0] FLASH_ADDR_MASK = 21'h0FFFFF;
  localparam logic [20:0] PROM_ADDR_MASK = 21'h07FFFF;
  localparam int BP_BYTE_CYC = 4;
  localparam logic [3:0] BP_CYC_LAST = 4'(BP_BYTE_CYC - 1);

  typedef enum logic [3:0] {
    RGN_EXT, RGN_FLASH, RGN_PROM, RGN_DRAM, RGN_SRAM, RGN_LIO,
    RGN_REGS, RGN_VME16, RGN_HOLE, RGN_IACK
  } lbda_rgn_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [1:0] transfer_type;
    logic write;
    logic [31:0] wdata;
  } lbda_req_t;

  typedef struct packed {
    logic [20:0] addr;
    logic flash_cs;
    logic prom_cs;
    logic oe;
    logic we;
    logic [7:0] wdata;
  } lbda_pbus_t;

endpackage

// ---- logic/lbda_top.sv ----
// Local bus address decoder, access timeout and fixed-priority arbiter.
// Assumes only the granted master starts cycles and slaves ack by level.
// Operation
// [RULE_01] Grant priority LAN 0 highest, SCSI 1, VMEbus 2, processor 3 lowest.
// [RULE_02] Enabled timeout ends an overlong access with transfer error ack.
// [RULE_03] Timeout limit selectable: 8 us, 64 us, 256 us or never.
// [RULE_04] Timeout counter idles during cycles bound for the VMEbus.
// [RULE_05] Transfer types 0, 1, 2 are normal; only they use the map.
// [RULE_06] Local resources answer normal and interrupt acknowledge types only.
// [RULE_07] After reset boot memory answers high window and low alias at zero.
// [RULE_08] Software disables the low boot alias before enabling DRAM.
// [RULE_09] DRAM decode enabled by bit 24 of the DRAM control register.
// [RULE_10] Low boot alias disabled by bit 20 of boot memory control.
// [RULE_11] Jumper fitted: high window flash, alternate PROM; absent swaps them.
// [RULE_12] 32-bit boot accesses become byte transfers; small devices alias.
// [RULE_13] Two holes stay undecoded; unclaimed accesses end only by timeout.
// [RULE_14] Software marks onboard I/O non-cacheable and serialized.
// [RULE_15] Timeout counter restarts at each cycle start, clears on ack.
// [RULE_16] Ownership changes only between cycles, never mid-transfer.
`timescale 1ns/10ps
module lbda_top #(
  parameter int TMO_64_CYC_P = lbda_pkg::TMO_64_CYC,   // 64 us count
  parameter int TMO_256_CYC_P = lbda_pkg::TMO_256_CYC  // 256 us count
) (
  input wire logic mclk_i,                   // Local bus clock
  input wire logic rst_n_i,                  // Async reset, active low
  input wire logic [3:0] bus_req_i,          // Requests, bit 0 LAN
  output logic [3:0] bus_grant_o,            // One-hot grant
  input wire logic ts_i,                     // Cycle start pulse
  input wire lbda_pkg::lbda_req_t req_i,     // Address, type, data
  input wire logic vme_bound_i,              // Cycle goes offboard
  input wire logic slave_ack_i,              // Ack from outside slave
  input wire logic boot_select_jumper_i,     // Jumper fitted
  output logic ta_o,                         // Cycle ack pulse
  output logic transfer_error_ack_o,         // Timeout error ack pulse
  output logic [31:0] rdata_o,               // Read data of own slaves
  output lbda_pkg::lbda_rgn_t rgn_o,         // Decoded region
  input wire logic [7:0] pb_rdata_i,         // Byte bus read data
  output lbda_pkg::lbda_pbus_t pb_o          // Byte bus strobes
);
  import lbda_pkg::*;

  logic busy_q, busy_d;
  lbda_req_t req_q, req_d;
  lbda_rgn_t rgn_q, rgn_d;
  logic vme_q, vme_d;
  logic bp_start_q, bp_start_d;
  logic ta_q, ta_d;
  logic tea_q, tea_d;
  logic [31:0] rdata_q, rdata_d;
  logic [31:0] boot_ctl_q, boot_ctl_d;
  logic [31:0] dram_ctl_q, dram_ctl_d;
  logic [TMO_CNT_W-1:0] cnt_q, cnt_d;
  logic [TMO_CNT_W-1:0] tmo_lim_m1;
  logic [3:0] grant_q, grant_d;
  logic [3:0] req_lsb;
  logic [1:0] tmo_sel;
  logic tmo_en, tmo_run, start, bp_done, own_ack;
  logic [31:0] bp_rdata;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic lbda_rgn_t rgn_decode(input logic [31:0] a, input logic [1:0] tt,
                                           input logic low_on, input logic dram_on,
                                           input logic jmp);
    lbda_rgn_t r;
    // [RULE_11] Jumper picks flash or PROM
    lbda_rgn_t hi_dev;
    lbda_rgn_t alt_dev;
    hi_dev = jmp ? RGN_FLASH : RGN_PROM;
    alt_dev = jmp ? RGN_PROM : RGN_FLASH;
    r = RGN_EXT;
    // [RULE_05] Map applies to normal types
    // [RULE_06] Acknowledge cycles kept apart
    if (tt == TT_IACK) r = RGN_IACK;
    else if ((a & BOOT_WIN_MASK) == BOOT_HI_BASE) r = hi_dev;
    else if ((a & BOOT_WIN_MASK) == BOOT_ALT_BASE) r = alt_dev;
    // [RULE_13] Holes left undecoded
    else if ((a & HOLE1_MASK) == HOLE1_BASE) r = RGN_HOLE;
    else if ((a & HALF_MB_MASK) == HOLE2_BASE) r = RGN_HOLE;
    else if ((a & HALF_MB_MASK) == SRAM_DEF_BASE) r = RGN_SRAM;
    else if (a[31:2] == BOOT_CTL_ADDR[31:2] || a[31:2] == DRAM_CTL_ADDR[31:2])
      r = RGN_REGS;
    else if ((a & VME16_MASK) == VME16_BASE) r = RGN_VME16;
    else if ((a & LIO_MASK) == LIO_BASE) r = RGN_LIO;
    // [RULE_07] Low alias while enabled
    else if (low_on && (a & BOOT_LOW_MASK) == BOOT_LOW_BASE) r = hi_dev;
    // [RULE_09] DRAM only when enabled
    else if (dram_on && (a & DRAM_MASK) == DRAM_BASE) r = RGN_DRAM;
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Timeout limit
  // ----------------------------------------------------------------
  assign tmo_en = boot_ctl_q[TMO_EN_BIT];
  assign tmo_sel = boot_ctl_q[TMO_SEL_LSB +: 2];
  // [RULE_04] No timing for offboard cycles
  assign tmo_run = tmo_en && (tmo_sel != TMO_SEL_NEVER) && !vme_q;

  // [RULE_03] Four selectable limits
  always_comb begin
    unique case (tmo_sel)
      TMO_SEL_8: tmo_lim_m1 = TMO_CNT_W'(TMO_8_CYC - 1);
      TMO_SEL_64: tmo_lim_m1 = TMO_CNT_W'(TMO_64_CYC_P - 1);
      TMO_SEL_256: tmo_lim_m1 = TMO_CNT_W'(TMO_256_CYC_P - 1);
      TMO_SEL_NEVER: tmo_lim_m1 = '1;
    endcase
  end

  // ----------------------------------------------------------------
  // Cycle control, registers and timeout
  // ----------------------------------------------------------------
  assign start = !busy_q && ts_i;
  assign own_ack = (rgn_q == RGN_REGS) || bp_done ||
                   (slave_ack_i && rgn_q != RGN_FLASH && rgn_q != RGN_PROM);

  always_comb begin
    busy_d = busy_q;
    req_d = req_q;
    rgn_d = rgn_q;
    vme_d = vme_q;
    bp_start_d = 1'b0;
    ta_d = 1'b0;
    tea_d = 1'b0;
    rdata_d = rdata_q;
    boot_ctl_d = boot_ctl_q;
    dram_ctl_d = dram_ctl_q;
    cnt_d = cnt_q;
    if (start) begin
      busy_d = 1'b1;
      req_d = req_i;
      rgn_d = rgn_decode(req_i.addr, req_i.transfer_type,
                         !boot_ctl_q[BOOT_LOW_OFF_BIT], dram_ctl_q[DRAM_EN_BIT],
                         boot_select_jumper_i);
      vme_d = vme_bound_i || (rgn_d == RGN_VME16);
      bp_start_d = (rgn_d == RGN_FLASH) || (rgn_d == RGN_PROM);
      // [RULE_15] Fresh count per cycle
      cnt_d = '0;
    end else if (busy_q) begin
      if (tmo_run) cnt_d = cnt_q + 1'b1;
      if (rgn_q == RGN_REGS) begin
        // [RULE_10] Alias-off bit writable
        if (req_q.addr[31:2] == BOOT_CTL_ADDR[31:2]) begin
          if (req_q.write) boot_ctl_d = req_q.wdata;
          rdata_d = boot_ctl_q;
        end else begin
          if (req_q.write) dram_ctl_d = req_q.wdata;
          rdata_d = dram_ctl_q;
        end
      end else if (bp_done) begin
        rdata_d = bp_rdata;
      end
      if (own_ack) begin
        ta_d = 1'b1;
        busy_d = 1'b0;
        // [RULE_15] Count cleared on ack
        cnt_d = '0;
      end else if (tmo_run && cnt_q == tmo_lim_m1) begin
        // [RULE_02] Error ack ends stalled cycle
        tea_d = 1'b1;
        busy_d = 1'b0;
        cnt_d = '0;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_q <= 1'b0;
      req_q <= '0;
      rgn_q <= RGN_EXT;
      vme_q <= 1'b0;
      bp_start_q <= 1'b0;
      ta_q <= 1'b0;
      tea_q <= 1'b0;
      rdata_q <= 32'h00000000;
      boot_ctl_q <= BOOT_CTL_RST;
      dram_ctl_q <= DRAM_CTL_RST;
      cnt_q <= '0;
    end else begin
      busy_q <= busy_d;
      req_q <= req_d;
      rgn_q <= rgn_d;
      vme_q <= vme_d;
      bp_start_q <= bp_start_d;
      ta_q <= ta_d;
      tea_q <= tea_d;
      rdata_q <= rdata_d;
      boot_ctl_q <= boot_ctl_d;
      dram_ctl_q <= dram_ctl_d;
      cnt_q <= cnt_d;
    end
  end

  // ----------------------------------------------------------------
  // Arbiter
  // ----------------------------------------------------------------
  always_comb begin
    grant_d = grant_q;
    // [RULE_16] Regrant only when bus idle
    if (!busy_q && !ts_i && bus_req_i != 4'h0) begin
      grant_d = 4'h0;
      // [RULE_01] Lowest index wins, scanned last
      for (int i = LBDA_MASTERS - 1; i >= 0; i--) begin
        if (bus_req_i[i]) begin
          grant_d = 4'h0;
          grant_d[i] = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) grant_q <= GRANT_RST;
    else grant_q <= grant_d;
  end

  lbda_byte_port u_byte_port (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .start_i(bp_start_q),
    .flash_i(rgn_q == RGN_FLASH),
    .req_i(req_q),
    .pb_rdata_i(pb_rdata_i),
    .pb_o(pb_o),
    .done_o(bp_done),
    .rdata_o(bp_rdata)
  );

  assign bus_grant_o = grant_q;
  assign ta_o = ta_q;
  assign transfer_error_ack_o = tea_q;
  assign rdata_o = rdata_q;
  assign rgn_o = rgn_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  assign req_lsb = bus_req_i & (~bus_req_i + 4'h1);

  sequence s_hi_window;
    start && req_i.transfer_type != TT_IACK &&
      (req_i.addr & BOOT_WIN_MASK) == BOOT_HI_BASE;
  endsequence
  sequence s_low_boot;
    start && req_i.transfer_type != TT_IACK &&
      (req_i.addr & BOOT_LOW_MASK) == BOOT_LOW_BASE;
  endsequence

  property p_grant_prio;
    (!busy_q && !ts_i && bus_req_i != 4'h0) |=> bus_grant_o == $past(req_lsb);
  endproperty
  a_grant_prio: assert property (p_grant_prio) // [RULE_01]
    else $error("grant not given to highest priority requester");

  property p_grant_hold;
    (busy_q || ts_i) |=> $stable(bus_grant_o);
  endproperty
  a_grant_hold: assert property (p_grant_hold) // [RULE_16]
    else $error("grant moved during a cycle");

  property p_tmo_fire;
    (busy_q && !start && tmo_run && cnt_q == tmo_lim_m1 && !own_ack)
      |=> transfer_error_ack_o && !busy_q;
  endproperty
  a_tmo_fire: assert property (p_tmo_fire) // [RULE_02]
    else $error("timeout did not end the cycle with error ack");

  property p_tmo_limit;
    transfer_error_ack_o |-> $past(tmo_sel) != TMO_SEL_NEVER &&
      $past(cnt_q) == $past(tmo_lim_m1);
  endproperty
  a_tmo_limit: assert property (p_tmo_limit) // [RULE_03]
    else $error("error ack not at the selected limit");

  property p_vme_quiet;
    (busy_q && vme_q) |=> !transfer_error_ack_o && $stable(cnt_q);
  endproperty
  a_vme_quiet: assert property (p_vme_quiet) // [RULE_04]
    else $error("timeout ran on an offboard cycle");

  property p_iack;
    (start && req_i.transfer_type == TT_IACK) |=> rgn_q == RGN_IACK && !bp_start_q;
  endproperty
  a_iack: assert property (p_iack) // [RULE_06]
    else $error("acknowledge cycle decoded into memory map");

  property p_jumper;
    s_hi_window |=> rgn_q == ($past(boot_select_jumper_i) ? RGN_FLASH : RGN_PROM);
  endproperty
  a_jumper: assert property (p_jumper) // [RULE_11]
    else $error("boot window reached wrong device");

  property p_low_alias;
    (s_low_boot ##0 !boot_ctl_q[BOOT_LOW_OFF_BIT]) |=> bp_start_q;
  endproperty
  a_low_alias: assert property (p_low_alias) // [RULE_07]
    else $error("low boot alias not decoded");

  property p_alias_off;
    (s_low_boot ##0 boot_ctl_q[BOOT_LOW_OFF_BIT])
      |=> rgn_q == ($past(dram_ctl_q[DRAM_EN_BIT]) ? RGN_DRAM : RGN_EXT);
  endproperty
  a_alias_off: assert property (p_alias_off) // [RULE_10]
    else $error("low alias still decoded or DRAM decode wrong");

  property p_hole;
    (busy_q && rgn_q == RGN_HOLE && !slave_ack_i) |=> !ta_o;
  endproperty
  a_hole: assert property (p_hole) // [RULE_13]
    else $error("hole acknowledged without a claimer");

  property p_cnt_restart;
    start |=> cnt_q == '0 ##1 (busy_q && tmo_run) [*2] |-> cnt_q != '0;
  endproperty
  a_cnt_restart: assert property (p_cnt_restart) // [RULE_15]
    else $error("timeout count not restarted per cycle");

endmodule // lbda_top
